// [core/fpes_pkg.sv]
// Purpose: shared constants and types of the floating-point exception status logic
// Assumes: one 125 MHz clock, classic Wishbone register access
// Notes:   status image uses bit 31 for the first printed field, counting downward
package fpes_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone register offsets
  localparam logic [7:0] ADR_STATUS   = 8'h00;
  localparam logic [7:0] ADR_SETBITS  = 8'h04;
  localparam logic [7:0] ADR_MSTATE   = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADR_IRQ_EN   = 8'h14;
  localparam logic [7:0] ADR_LAST     = 8'h18;

  //////////////////////////////////////////////////////////////////////////////
  // status image field positions
  localparam int POS_FX   = 31;
  localparam int POS_FEX  = 30;
  localparam int POS_VX   = 29;
  localparam int POS_OX   = 28;
  localparam int POS_UX   = 27;
  localparam int POS_ZX   = 26;
  localparam int POS_XX   = 25;
  localparam int POS_SNAN = 24;
  localparam int POS_ISI  = 23;
  localparam int POS_IDI  = 22;
  localparam int POS_ZDZ  = 21;
  localparam int POS_IMZ  = 20;
  localparam int POS_VC   = 19;
  localparam int POS_CLS  = 12;
  localparam int POS_SOFT = 10;
  localparam int POS_SQRT = 9;
  localparam int POS_CVI  = 8;
  localparam int POS_VE   = 7;
  localparam int POS_OE   = 6;
  localparam int POS_UE   = 5;
  localparam int POS_ZE   = 4;
  localparam int POS_XE   = 3;

  // index of each invalid sub-condition in the invalid vector
  localparam int INV_SNAN = 8;
  localparam int INV_ISI  = 7;
  localparam int INV_IDI  = 6;
  localparam int INV_ZDZ  = 5;
  localparam int INV_IMZ  = 4;
  localparam int INV_VC   = 3;
  localparam int INV_SOFT = 2;
  localparam int INV_SQRT = 1;
  localparam int INV_CVI  = 0;

  // interrupt event bits
  localparam int EV_PROG  = 0;
  localparam int EV_SUPP  = 1;
  localparam int EV_ILL   = 2;
  localparam int EV_WIDTH = 3;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0]         STATUS_RST = 32'h0000_0000;
  localparam logic [1:0]          MSTATE_RST = 2'h0;
  localparam logic [EV_WIDTH-1:0] IRQ_EN_RST = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // result class codes
  localparam logic [4:0] CODE_QNAN  = 5'h11;
  localparam logic [4:0] CODE_NINF  = 5'h09;
  localparam logic [4:0] CODE_NNORM = 5'h08;
  localparam logic [4:0] CODE_NDEN  = 5'h18;
  localparam logic [4:0] CODE_NZERO = 5'h12;
  localparam logic [4:0] CODE_PZERO = 5'h02;
  localparam logic [4:0] CODE_PDEN  = 5'h14;
  localparam logic [4:0] CODE_PNORM = 5'h04;
  localparam logic [4:0] CODE_PINF  = 5'h05;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    CLS_QNAN, CLS_NINF, CLS_NNORM, CLS_NDEN, CLS_NZERO,
    CLS_PZERO, CLS_PDEN, CLS_PNORM, CLS_PINF
  } fpes_class_t;

  typedef enum logic [1:0] {
    KIND_OTHER, KIND_MULADD, KIND_CMP_ORD, KIND_CVT_INT
  } fpes_kind_t;

  typedef enum logic [1:0] {
    MODE_IGNORE     = 2'b00,
    MODE_IMP_NONREC = 2'b01,
    MODE_IMP_REC    = 2'b10,
    MODE_PRECISE    = 2'b11
  } fpes_mode_t;

  typedef struct packed {
    logic [8:0] inv;
    logic       zx;
    logic       ox;
    logic       ux;
    logic       xx;
  } fpes_cond_t;

  typedef struct packed {
    logic        valid;
    fpes_kind_t  kind;
    fpes_class_t cls;
    fpes_cond_t  cond;
  } fpes_cmpl_t;

  // trap_sel order: invalid, overflow, underflow, zero divide, inexact
  typedef struct packed {
    logic       done;
    logic       write_dest;
    logic       suppress;
    logic       default_result;
    logic [4:0] trap_sel;
    logic       prog_exc;
    logic       illegal;
  } fpes_resp_t;

endpackage : fpes_pkg

// [core/fpes_class_enc.sv]
// Purpose: result class to five-bit class field code
// Assumes: combinational, caller registers the code
// Notes:   illegal enum codes give zero
`timescale 1ns/100ps
`default_nettype none
module fpes_class_enc
  import fpes_pkg::*;
(
  // class in
  input  wire fpes_pkg::fpes_class_t cls,
  // code out
  output logic [4:0]                 code
);

  always_comb begin
    unique case (cls)
      CLS_QNAN:  code = CODE_QNAN;
      CLS_NINF:  code = CODE_NINF;
      CLS_NNORM: code = CODE_NNORM;
      CLS_NDEN:  code = CODE_NDEN;
      CLS_NZERO: code = CODE_NZERO;
      CLS_PZERO: code = CODE_PZERO;
      CLS_PDEN:  code = CODE_PDEN;
      CLS_PNORM: code = CODE_PNORM;
      CLS_PINF:  code = CODE_PINF;
      default:   code = 5'h00;
    endcase
  end

endmodule : fpes_class_enc
`default_nettype wire

// [core/fpes_combo_chk.sv]
// Purpose: flags condition sets that one instruction may not raise together
// Assumes: combinational on the completion record
// Notes:   high output means an illegal combination
`timescale 1ns/100ps
`default_nettype none
module fpes_combo_chk
  import fpes_pkg::*;
(
  // completion in
  input  wire fpes_pkg::fpes_cond_t cond,
  input  wire fpes_pkg::fpes_kind_t kind,
  // verdict
  output logic                      illegal
);

  logic [8:0] inv_others;
  logic [4:0] cats;
  logic       cat_ok;
  logic       inv_ok;

  always_comb begin
    inv_others           = cond.inv;
    inv_others[INV_SNAN] = 1'b0;
    cats                 = {|cond.inv, cond.zx, cond.ox, cond.ux, cond.xx};
    cat_ok = $onehot0(cats) || cats == 5'b00101 || cats == 5'b00011;
    inv_ok = $onehot0(cond.inv)
          || (cond.inv[INV_SNAN] && inv_others == 9'h010 && kind == KIND_MULADD)
          || (cond.inv[INV_SNAN] && inv_others == 9'h008 && kind == KIND_CMP_ORD)
          || (cond.inv[INV_SNAN] && inv_others == 9'h001 && kind == KIND_CVT_INT);
    illegal = !(cat_ok && inv_ok);
  end

endmodule : fpes_combo_chk
`default_nettype wire

// [core/fpes_core.sv]
// Purpose: floating-point exception status logic with Wishbone register access
// Assumes: completion records come from logic on mclk, one per cycle at most
// Notes:   registered answer one cycle after each completion
//
// Functional notes
// - encode result class into five-bit field
// - invalid sets summary and matching sticky sub-bit
// - divide-by-zero sets zero-divide sticky bit
// - overflow, underflow, inexact set their sticky bits
// - no enabled condition delivers default result
// - instruction raising any bit 0-to-1 sets summary
// - software setting condition bit sets summary
// - enabled summary when set bit is enabled
// - program exception needs summary and trap mode
// - destination writing ignores trap-mode bits
// - only inexact pairs with overflow or underflow
// - signaling-operand pairs only with listed invalid bits
// - enabled invalid or zero-divide suppresses writing
// - all other conditions write the destination
// - enable selects trap-enabled or default result
// - handler only for enabled, non-ignore mode
// - decode trap-mode bits into four modes
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fpes_core
  import fpes_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // execution pipeline
  input  wire fpes_pkg::fpes_cmpl_t  cmpl,
  output fpes_pkg::fpes_resp_t       resp,
  output logic [4:0]                 result_class_field,
  // exception dispatch
  output fpes_pkg::fpes_mode_t       trap_mode,
  output logic                       irq
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [8:0]          inv_sticky;
  logic                overflow_sticky;
  logic                underflow_sticky;
  logic                zero_divide_sticky;
  logic                inexact_sticky;
  logic                exception_summary;
  logic [4:0]          enables;
  logic                trap_mode_bit_a;
  logic                trap_mode_bit_b;
  logic [EV_WIDTH-1:0] irq_stat;
  logic [EV_WIDTH-1:0] irq_en;

  logic [31:0]         cur_img;
  logic [31:0]         base_img;
  logic [31:0]         wr_mask;
  logic                bus_req;
  logic                bus_wr;
  logic                sw_wr;
  logic [12:0]         cur_exc;
  logic [12:0]         base_exc;
  logic [12:0]         hw_exc;
  logic [12:0]         next_exc;
  logic                next_fx;
  logic                next_fex;
  logic                invalid_op_summary;
  logic                enabled_exception_summary;
  logic [4:0]          class_code;
  logic                combo_illegal;
  logic                next_suppress;
  logic [4:0]          next_trap_sel;
  logic                next_prog;
  logic [EV_WIDTH-1:0] events;
  logic [31:0]         rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [12:0] img_exc(input logic [31:0] img);
    img_exc = {img[POS_SNAN], img[POS_ISI], img[POS_IDI], img[POS_ZDZ], img[POS_IMZ],
               img[POS_VC], img[POS_SOFT], img[POS_SQRT], img[POS_CVI],
               img[POS_ZX], img[POS_OX], img[POS_UX], img[POS_XX]};
  endfunction : img_exc

  function automatic logic [4:0] img_en(input logic [31:0] img);
    img_en = {img[POS_VE], img[POS_OE], img[POS_UE], img[POS_ZE], img[POS_XE]};
  endfunction : img_en

  // per-category view of the exception vector, same order as enables
  function automatic logic [4:0] exc_cats(input logic [12:0] exc);
    exc_cats = {|exc[12:4], exc[2], exc[1], exc[3], exc[0]};
  endfunction : exc_cats

  //////////////////////////////////////////////////////////////////////////////
  // submodules
  fpes_class_enc u_class_enc (
    .cls  (cmpl.cls),
    .code (class_code)
  );

  fpes_combo_chk u_combo_chk (
    .cond    (cmpl.cond),
    .kind    (cmpl.kind),
    .illegal (combo_illegal)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status image
  assign cur_exc = {inv_sticky, zero_divide_sticky, overflow_sticky,
                    underflow_sticky, inexact_sticky};
  assign invalid_op_summary        = |inv_sticky;
  assign enabled_exception_summary = |(exc_cats(cur_exc) & enables);

  always_comb begin
    cur_img                = STATUS_RST;
    cur_img[POS_FX]        = exception_summary;
    cur_img[POS_FEX]       = enabled_exception_summary;
    cur_img[POS_VX]        = invalid_op_summary;
    cur_img[POS_OX]        = overflow_sticky;
    cur_img[POS_UX]        = underflow_sticky;
    cur_img[POS_ZX]        = zero_divide_sticky;
    cur_img[POS_XX]        = inexact_sticky;
    cur_img[POS_SNAN]      = inv_sticky[INV_SNAN];
    cur_img[POS_ISI]       = inv_sticky[INV_ISI];
    cur_img[POS_IDI]       = inv_sticky[INV_IDI];
    cur_img[POS_ZDZ]       = inv_sticky[INV_ZDZ];
    cur_img[POS_IMZ]       = inv_sticky[INV_IMZ];
    cur_img[POS_VC]        = inv_sticky[INV_VC];
    cur_img[POS_SOFT]      = inv_sticky[INV_SOFT];
    cur_img[POS_SQRT]      = inv_sticky[INV_SQRT];
    cur_img[POS_CVI]       = inv_sticky[INV_CVI];
    cur_img[POS_CLS+:5]    = result_class_field;
    cur_img[POS_VE]        = enables[4];
    cur_img[POS_OE]        = enables[3];
    cur_img[POS_UE]        = enables[2];
    cur_img[POS_ZE]        = enables[1];
    cur_img[POS_XE]        = enables[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_we_i && wb_ack_o;
  assign sw_wr   = bus_wr && (wb_adr_i == ADR_STATUS || wb_adr_i == ADR_SETBITS);
  assign wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    if (sw_wr && wb_adr_i == ADR_STATUS) begin
      base_img = (cur_img & ~wr_mask) | (wb_dat_i & wr_mask);
    end else if (sw_wr) begin
      base_img = cur_img | (wb_dat_i & wr_mask);
    end else begin
      base_img = cur_img;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      ADR_STATUS:   rd_data = cur_img;
      ADR_MSTATE:   rd_data = {30'h0000_0000, trap_mode_bit_a, trap_mode_bit_b};
      ADR_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat};
      ADR_IRQ_EN:   rd_data = {29'h0000_0000, irq_en};
      ADR_LAST:     rd_data = {21'h00_0000, resp};
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && bus_req && !wb_ack_o) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky condition update
  assign base_exc = img_exc(base_img);
  assign hw_exc   = cmpl.valid ? cmpl.cond : 13'h0000;
  assign next_exc = base_exc | hw_exc;

  always_comb begin
    next_fx = base_img[POS_FX];
    if (|(hw_exc & ~base_exc)) begin
      next_fx = 1'b1;
    end
    if (sw_wr && |(base_exc & ~cur_exc)) begin
      next_fx = 1'b1;
    end
  end

  assign next_fex = |(exc_cats(next_exc) & img_en(base_img));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      inv_sticky         <= 9'h000;
      zero_divide_sticky <= 1'b0;
      overflow_sticky    <= 1'b0;
      underflow_sticky   <= 1'b0;
      inexact_sticky     <= 1'b0;
      exception_summary  <= 1'b0;
    end else if (ce) begin
      {inv_sticky, zero_divide_sticky, overflow_sticky,
       underflow_sticky, inexact_sticky} <= next_exc;
      exception_summary <= next_fx;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      enables <= 5'h00;
    end else if (ce && sw_wr) begin
      enables <= img_en(base_img);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      result_class_field <= STATUS_RST[POS_CLS+:5];
    end else if (ce && cmpl.valid && !next_suppress) begin
      result_class_field <= class_code;
    end else if (ce && sw_wr) begin
      result_class_field <= base_img[POS_CLS+:5];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trap mode
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      {trap_mode_bit_a, trap_mode_bit_b} <= MSTATE_RST;
    end else if (ce && bus_wr && wb_adr_i == ADR_MSTATE && wb_sel_i[0]) begin
      {trap_mode_bit_a, trap_mode_bit_b} <= wb_dat_i[1:0];
    end
  end

  assign trap_mode = fpes_mode_t'({trap_mode_bit_a, trap_mode_bit_b});

  //////////////////////////////////////////////////////////////////////////////
  // completion answer
  always_comb begin
    next_trap_sel = exc_cats(hw_exc) & enables;
    next_suppress = cmpl.valid && (next_trap_sel[4] || next_trap_sel[1]);
    next_prog     = cmpl.valid && next_fx && next_fex
                 && trap_mode != MODE_IGNORE;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      resp <= '0;
    end else if (ce) begin
      resp.done           <= cmpl.valid;
      resp.suppress       <= next_suppress;
      resp.write_dest     <= cmpl.valid && !next_suppress;
      resp.default_result <= cmpl.valid && |hw_exc && next_trap_sel == 5'h00;
      resp.trap_sel       <= cmpl.valid ? next_trap_sel : 5'h00;
      resp.prog_exc       <= next_prog;
      resp.illegal        <= cmpl.valid && combo_illegal;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts
  assign events[EV_PROG] = next_prog;
  assign events[EV_SUPP] = next_suppress;
  assign events[EV_ILL]  = cmpl.valid && combo_illegal;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else if (ce && bus_wr && wb_adr_i == ADR_IRQ_CLR && wb_sel_i[0]) begin
      irq_stat <= (irq_stat & ~wb_dat_i[EV_WIDTH-1:0]) | events;
    end else if (ce) begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_en <= IRQ_EN_RST;
    end else if (ce && bus_wr && wb_adr_i == ADR_IRQ_EN && wb_sel_i[0]) begin
      irq_en <= wb_dat_i[EV_WIDTH-1:0];
    end
  end

  assign irq = |(irq_stat & irq_en);

endmodule : fpes_core
`default_nettype wire

// [dv/fpes_core_sva.sv]
// Purpose: port assertions for fpes_core
// Assumes: single clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module fpes_core_sva
  import fpes_pkg::*;
(
  // clock, reset, enable
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 ce,
  // wishbone
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // pipeline and dispatch
  input wire fpes_pkg::fpes_cmpl_t cmpl,
  input wire fpes_pkg::fpes_resp_t resp,
  input wire logic [4:0]           result_class_field,
  input wire fpes_pkg::fpes_mode_t trap_mode,
  input wire logic                 irq
);
  localparam logic [4:0] CODES [9] = '{CODE_QNAN, CODE_NINF, CODE_NNORM, CODE_NDEN, CODE_NZERO,
                                       CODE_PZERO, CODE_PDEN, CODE_PNORM, CODE_PINF};
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_req; ce && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_cmpl; ce && cmpl.valid; endsequence
  ////////////////////////////////////////////////////////////
  chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  chk_resp_done: assert property (ce |=> resp.done == $past(cmpl.valid)) else $error("done misplaced");
  chk_mode_write: assert property ($changed(trap_mode) |->
    $past(wb_ack_o && wb_we_i && wb_adr_i == ADR_MSTATE)) else $error("trap mode moved unasked");
  chk_class_code: assert property (resp.write_dest |->
    result_class_field == CODES[$past(cmpl.cls)]) else $error("class code wrong");
  chk_default_res: assert property (resp.done |->
    resp.default_result == ($past(cmpl.cond) != 0 && resp.trap_sel == 0)) else $error("default flag wrong");
  chk_suppress_sel: assert property (resp.done |->
    resp.suppress == (resp.trap_sel[4] || resp.trap_sel[1])) else $error("suppress wrong");
  chk_write_dest: assert property (resp.done |-> resp.write_dest == !resp.suppress)
    else $error("write flag wrong");
  chk_prog_mode: assert property (resp.prog_exc |-> resp.done && trap_mode != MODE_IGNORE)
    else $error("program exception in ignore mode");
  chk_prog_raise: assert property (s_cmpl ##1 (resp.trap_sel != 0 && trap_mode != MODE_IGNORE)
    |-> resp.prog_exc) else $error("program exception missing");
  chk_combo_bad: assert property (s_cmpl ##0 (cmpl.cond.ox && cmpl.cond.ux) |=> resp.illegal)
    else $error("bad pair not flagged");
  chk_snan_pair: assert property (s_cmpl ##0 (cmpl.cond.inv[INV_SNAN] && cmpl.cond.inv[INV_ISI])
    |=> resp.illegal) else $error("bad invalid pair not flagged");
endmodule : fpes_core_sva
`default_nettype wire

// [dv/fpes_pipe_model.sv]
// Purpose: behavioural execution pipeline issuing completion records
// Assumes: called just after a rising edge
// Notes:   idle cycles carry an inverted payload with valid low
`timescale 1ns/100ps
`default_nettype none
module fpes_pipe_model
  import fpes_pkg::*;
(
  // clock
  input  wire logic                mclk,
  // completion record
  output var fpes_pkg::fpes_cmpl_t cmpl
);
  initial cmpl = '0;
  // gap 0 keeps valid up for a back-to-back record
  task automatic issue(input fpes_cmpl_t r, input int gap);
    cmpl <= r;
    @(posedge mclk);
    if (gap > 0) begin
      cmpl <= {1'b0, ~r[$bits(fpes_cmpl_t)-2:0]};
      repeat (gap) @(posedge mclk);
    end
  endtask : issue
endmodule : fpes_pipe_model
`default_nettype wire

// [dv/fpes_core_tb.sv]
// Purpose: self-checking bench of fpes_core
// Assumes: 125 MHz mclk, inputs driven at the rising edge
// Notes:   status shadow in st, expected results queued for the monitor
`timescale 1ns/100ps
`default_nettype none
module fpes_core_tb;
  import fpes_pkg::*;
  localparam logic [31:0] COND_M = 32'h1ff8_0700;
  localparam logic [31:0] INV_M  = 32'h01f8_0700;
  localparam logic [4:0]  CODES [9] = '{CODE_QNAN, CODE_NINF, CODE_NNORM, CODE_NDEN, CODE_NZERO,
                                        CODE_PZERO, CODE_PDEN, CODE_PNORM, CODE_PINF};
  localparam logic [12:0] PICK [8] = '{13'h0004, 13'h0008, 13'h1000, 13'h0005,
                                       13'h0003, 13'h1100, 13'h0006, 13'h1800};
  logic        mclk, resetn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, st, v;
  logic [4:0]  result_class_field;
  logic [2:0]  ev;
  logic [1:0]  md;
  fpes_cmpl_t  cmpl;
  fpes_resp_t  resp;
  fpes_mode_t  trap_mode;
  int          num_errors, compares, seed;
  logic [31:0] q_rd [$];
  logic [15:0] q_rs [$];
  always #4 mclk = ~mclk;
  fpes_core fpes_core_inst (.mclk(mclk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmpl(cmpl), .resp(resp), .result_class_field(result_class_field),
    .trap_mode(trap_mode), .irq(irq));
  fpes_pipe_model fpes_pipe_model_inst (.mclk(mclk), .cmpl(cmpl));
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
    int n = 0;
    q_rd.push_back(we ? 32'h0 : x);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      conclude();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge mclk);
  endtask : wb
  task automatic wst(input logic [31:0] d);
    wb(1'b1, ADR_STATUS, d, '0);
    st = d;
  endtask : wst
  function automatic void upd(input logic [31:0] cb);
    if ((cb & ~st & COND_M) != 0) st[POS_FX] = 1'b1;
    st = st | cb;
    st[POS_VX] = |(st & INV_M);
    st[POS_FEX] = |({st[POS_VX], st[POS_OX], st[POS_UX], st[POS_ZX], st[POS_XX]} & st[7:3]);
  endfunction : upd
  task automatic fire(input fpes_kind_t k, input fpes_class_t c, input logic [12:0] d, input int gap);
    logic [4:0] ts;
    logic       sup, prog, ill;
    fpes_cond_t cd;
    cd = d;
    ts = {cd.inv != 0 && st[POS_VE], cd.ox & st[POS_OE], cd.ux & st[POS_UE], cd.zx & st[POS_ZE], cd.xx & st[POS_XE]};
    sup = ts[4] | ts[1];
    ill = $countones(d) > 1 && !(d == 13'h0005 || d == 13'h0003 || k == KIND_MULADD && d == 13'h1100
          || k == KIND_CMP_ORD && d == 13'h1080 || k == KIND_CVT_INT && d == 13'h1010);
    upd({3'h0, cd.ox, cd.ux, cd.zx, cd.xx, cd.inv[8:3], 8'h00, cd.inv[2:0], 8'h00});
    prog = st[POS_FX] & st[POS_FEX] & (md != 2'b00);
    if (!sup) st[16:12] = CODES[c];
    ev = ev | {ill, sup, prog};
    q_rs.push_back({st[16:12], 1'b1, !sup, sup, d != 0 && ts == 0, ts, prog, ill});
    fpes_pipe_model_inst.issue({1'b1, k, c, cd}, gap);
  endtask : fire
  ////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1) check("wb_dat_o", wb_dat_o, q_rd.pop_front());
    if (resp.done === 1'b1) check("resp", {result_class_field, resp}, q_rs.pop_front());
  end
  initial begin
    {mclk, resetn, ce, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b00_1000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    num_errors = 0;
    compares = 0;
    seed = 32'h9d47_262c;
    st = STATUS_RST;
    md = MSTATE_RST;
    ev = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, ADR_STATUS, '0, STATUS_RST);
    wb(1'b0, ADR_MSTATE, '0, {30'h0, MSTATE_RST});
    wb(1'b0, ADR_IRQ_EN, '0, {29'h0, IRQ_EN_RST});
    wb(1'b0, ADR_LAST, '0, '0);
    wb(1'b1, 8'h1c, 32'hffff_ffff, '0);
    wb(1'b0, 8'h1c, '0, '0);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, ADR_MSTATE, m, '0);
      md = m[1:0];
      check("trap_mode", trap_mode, m);
      wst(32'h1 << POS_ZE);
      fire(KIND_OTHER, CLS_PNORM, 13'h0008, 1);
      wb(1'b0, ADR_MSTATE, '0, m);
    end
    for (int i = 0; i < 18; i++) begin
      v = $random(seed);
      md = v[1:0];
      wb(1'b1, ADR_MSTATE, v, '0);
      wst({24'h0, v[12:8], 3'h0});
      fire(fpes_kind_t'(v[17:16]), fpes_class_t'(i % 9), i < 9 ? 13'h0010 << i : 13'h0, 0);
      fire(fpes_kind_t'(v[19:18]), fpes_class_t'((i + 4) % 9), PICK[v[22:20]], 1);
      wb(1'b0, ADR_STATUS, '0, st);
    end
    wst('0);
    wb(1'b1, ADR_SETBITS, 32'h1 << POS_OX, '0);
    upd(32'h1 << POS_OX);
    fire(KIND_OTHER, CLS_PZERO, '0, 1);
    wb(1'b0, ADR_STATUS, '0, st);
    wb(1'b1, ADR_IRQ_CLR, 32'h7, '0);
    ev = '0;
    wb(1'b1, ADR_MSTATE, 32'h3, '0);
    md = 2'b11;
    wst(32'h1 << POS_VE);
    fire(KIND_OTHER, CLS_QNAN, 13'h0080, 1);
    wb(1'b0, ADR_IRQ_STAT, '0, ev);
    check("irq", irq, 1'b0);
    wb(1'b1, ADR_IRQ_STAT, '0, '0);
    wb(1'b1, ADR_IRQ_EN, 32'h1, '0);
    check("irq", irq, 1'b1);
    wb(1'b1, ADR_IRQ_CLR, 32'h1, '0);
    ev[EV_PROG] = 1'b0;
    check("irq", irq, 1'b0);
    wb(1'b0, ADR_IRQ_STAT, '0, ev);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    st = STATUS_RST;
    wb(1'b0, ADR_STATUS, '0, st);
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule : fpes_core_tb
bind fpes_core fpes_core_sva fpes_core_sva_inst (.mclk(mclk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmpl(cmpl), .resp(resp), .result_class_field(result_class_field),
  .trap_mode(trap_mode), .irq(irq));
`default_nettype wire
